// File: include/scsc_pkg.sv
/*
  Constants, state encoding and field layouts of the serial
  configuration and sync reference clock control bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scsc_pkg;

  // ==========================================================
  // Serial frame
  localparam int ADDR_W = 15;
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic RW_READ = 1'b1;

  // ==========================================================
  // Register offsets
  localparam logic [14:0] OFS_IF_CFG = 15'h0000;
  localparam logic [14:0] OFS_USER_CFG = 15'h0010;
  localparam logic [14:0] OFS_CLOCK_CONTROL_PRIMARY = 15'h0029;
  localparam logic [14:0] OFS_CLOCK_CONTROL_SECONDARY = 15'h002A;
  localparam logic [14:0] OFS_POS_LO = 15'h002C;
  localparam logic [14:0] OFS_POS_MID = 15'h002D;
  localparam logic [14:0] OFS_POS_HI = 15'h002E;
  localparam logic [14:0] OFS_FSA_LO = 15'h0030;
  localparam logic [14:0] OFS_FSA_HI = 15'h0031;
  localparam logic [14:0] OFS_FSB_LO = 15'h0032;
  localparam logic [14:0] OFS_FSB_HI = 15'h0033;
  localparam logic [14:0] OFS_REF_BYP = 15'h0038;
  localparam logic [14:0] OFS_TS_CTRL = 15'h003B;

  // ==========================================================
  // Field positions
  localparam int IF_DIR_BIT = 5;
  localparam int IF_4WIRE_BIT = 4;
  localparam int USER_HOLD_BIT = 0;
  localparam logic [3:0] SEL_AUTO = 4'h0;

  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic rsvd;
    logic proc_en;
    logic recv_en;
    logic zoom;
    logic [3:0] sel;
  } scsc_cc0_s;

  typedef struct packed {
    logic [4:0] rsvd;
    logic clk_pecl;
    logic ref_pecl;
    logic invert;
  } scsc_cc1_s;

  // ==========================================================
  // Reset values
  localparam logic RST_DIR = 1'b1;
  localparam logic [7:0] RST_USER = 8'h00;
  localparam scsc_cc0_s RST_CC0 = 8'h00;
  localparam scsc_cc1_s RST_CC1 = 8'h20;
  localparam logic [15:0] RST_FS = 16'hA000;
  localparam logic [7:0] RST_REF = 8'h00;
  localparam logic [7:0] RST_TS = 8'h00;

  // ==========================================================
  // Serial state, Gray along idle, instruction, data
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b11
  } scsc_state_e;

endpackage

// File: core/scsc_regs.sv
/*
  Serial configuration and sync reference clock control bank,
  reached over a 4-wire serial port with streaming access.
  Assumes SCLK, SCS_N, SDI and SYNC_REF_IN synchronous to CLK,
  with SCLK well below half the CLK rate.
*/
`timescale 1ns/1ps
module scsc_regs #(
  parameter int ADDR_W = scsc_pkg::ADDR_W
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SCLK,
  input wire logic SCS_N,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  input wire logic SYNC_REF_IN,
  input wire logic [23:0] SYNC_CAPTURE_POSITION,
  output logic SYNC_REF_RECEIVER_ENABLE,
  output logic SYNC_REF_PROCESSOR_ENABLE,
  output logic CAPTURE_POSITION_MAGNIFY,
  output logic [3:0] SYNC_REF_DELAY_SELECT,
  output logic AUTO_CAL_EN,
  output logic SYNC_REF_EVENT,
  output logic SAMPLE_CLOCK_PECL_MODE,
  output logic SYNC_REF_PECL_MODE,
  output logic [15:0] FS_ADJUST_A,
  output logic [15:0] FS_ADJUST_B,
  output logic REF_BYPASS,
  output logic [1:0] TIMESTAMP_CTRL
);

  // ==========================================================
  // Elaboration check
  if (ADDR_W != scsc_pkg::ADDR_W) begin : g_chk
    $error("Address width must match the serial frame");
  end

  // ==========================================================
  // State
  scsc_pkg::scsc_state_e st_q, st_d;
  logic sclk_q, sclk_d;
  logic [3:0] cnt_q, cnt_d;
  logic rw_q, rw_d;
  logic [14:0] addr_q, addr_d;
  logic [15:0] shin_q, shin_d;
  logic [7:0] shout_q, shout_d;
  logic sdo_q, sdo_d;
  logic oe_q, oe_d;
  logic dir_q, dir_d;
  logic [7:0] user_q, user_d;
  scsc_pkg::scsc_cc0_s cc0_q, cc0_d;
  scsc_pkg::scsc_cc1_s cc1_q, cc1_d;
  logic [15:0] fsa_q, fsa_d;
  logic [15:0] fsb_q, fsb_d;
  logic [7:0] ref_q, ref_d;
  logic [7:0] ts_q, ts_d;
  logic sr_q, sr_d;
  logic srprev_q, srprev_d;
  logic evt_q, evt_d;
  logic auto_q, auto_d;

  logic rise;
  logic fall;
  logic step;
  logic hold;
  logic sr_pol;
  logic [15:0] sh_n;
  logic [7:0] wdat;

  // Edge detect on the serial clock
  assign rise = SCLK & ~sclk_q;
  assign fall = ~SCLK & sclk_q;
  assign step = rise & ~SCS_N & (st_q == scsc_pkg::ST_DATA) &
                (cnt_q == 4'h7);
  assign hold = user_q[scsc_pkg::USER_HOLD_BIT];
  assign sh_n = {shin_q[14:0], SDI};
  assign wdat = sh_n[7:0];

  // Next address after a streamed byte
  function automatic logic [14:0] next_addr(input logic [14:0] a);
    logic [14:0] n;
    n = a;
    if (!hold) begin
      n = dir_q ? 15'(a + 15'h0001) : 15'(a - 15'h0001);
    end
    return n;
  endfunction

  // Read decode, unmapped addresses read zero
  function automatic logic [7:0] rd_byte(input logic [14:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      scsc_pkg::OFS_IF_CFG: begin
        r[scsc_pkg::IF_DIR_BIT] = dir_q;
        r[scsc_pkg::IF_4WIRE_BIT] = 1'b1;
      end
      scsc_pkg::OFS_USER_CFG: r = user_q;
      scsc_pkg::OFS_CLOCK_CONTROL_PRIMARY: r = cc0_q;
      scsc_pkg::OFS_CLOCK_CONTROL_SECONDARY: r = cc1_q;
      scsc_pkg::OFS_POS_LO: r = SYNC_CAPTURE_POSITION[7:0];
      scsc_pkg::OFS_POS_MID: r = SYNC_CAPTURE_POSITION[15:8];
      scsc_pkg::OFS_POS_HI: r = SYNC_CAPTURE_POSITION[23:16];
      scsc_pkg::OFS_FSA_LO: r = fsa_q[7:0];
      scsc_pkg::OFS_FSA_HI: r = fsa_q[15:8];
      scsc_pkg::OFS_FSB_LO: r = fsb_q[7:0];
      scsc_pkg::OFS_FSB_HI: r = fsb_q[15:8];
      scsc_pkg::OFS_REF_BYP: r = ref_q;
      scsc_pkg::OFS_TS_CTRL: r = ts_q;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ==========================================================
  // Serial port and register writes
  always_comb begin
    st_d = st_q;
    sclk_d = SCLK;
    cnt_d = cnt_q;
    rw_d = rw_q;
    addr_d = addr_q;
    shin_d = shin_q;
    shout_d = shout_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    dir_d = dir_q;
    user_d = user_q;
    cc0_d = cc0_q;
    cc1_d = cc1_q;
    fsa_d = fsa_q;
    fsb_d = fsb_q;
    ref_d = ref_q;
    ts_d = ts_q;
    if (SCS_N) begin
      st_d = scsc_pkg::ST_IDLE;
      cnt_d = 4'h0;
      oe_d = 1'b0;
      sdo_d = 1'b0;
    end else begin
      if (st_q == scsc_pkg::ST_IDLE) begin
        st_d = scsc_pkg::ST_INSTR;
      end
      if (rise) begin
        shin_d = sh_n;
        cnt_d = cnt_q + 4'h1;
        if (st_q != scsc_pkg::ST_DATA &&
            cnt_q == 4'(scsc_pkg::INSTR_BITS - 1)) begin
          st_d = scsc_pkg::ST_DATA;
          cnt_d = 4'h0;
          rw_d = sh_n[15];
          addr_d = sh_n[14:0];
          if (sh_n[15] == scsc_pkg::RW_READ) begin
            shout_d = rd_byte(sh_n[14:0]);
            oe_d = 1'b1;
          end
        end else if (step) begin
          cnt_d = 4'h0;
          addr_d = next_addr(addr_q);
          if (rw_q == scsc_pkg::RW_READ) begin
            shout_d = rd_byte(next_addr(addr_q));
          end else begin
            case (addr_q)
              scsc_pkg::OFS_IF_CFG: dir_d = wdat[scsc_pkg::IF_DIR_BIT];
              scsc_pkg::OFS_USER_CFG: user_d = wdat;
              scsc_pkg::OFS_CLOCK_CONTROL_PRIMARY: cc0_d = wdat;
              scsc_pkg::OFS_CLOCK_CONTROL_SECONDARY: cc1_d = wdat;
              scsc_pkg::OFS_FSA_LO: fsa_d[7:0] = wdat;
              scsc_pkg::OFS_FSA_HI: fsa_d[15:8] = wdat;
              scsc_pkg::OFS_FSB_LO: fsb_d[7:0] = wdat;
              scsc_pkg::OFS_FSB_HI: fsb_d[15:8] = wdat;
              scsc_pkg::OFS_REF_BYP: ref_d = wdat;
              scsc_pkg::OFS_TS_CTRL: ts_d = wdat;
              default: ;
            endcase
          end
        end
      end
      // Read data shifts out on falling edges, MSB first
      if (fall && st_q == scsc_pkg::ST_DATA &&
          rw_q == scsc_pkg::RW_READ) begin
        sdo_d = shout_q[7];
        shout_d = {shout_q[6:0], 1'b0};
      end
    end
  end

  // Serial and register flip-flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q <= scsc_pkg::ST_IDLE;
      sclk_q <= 1'b0;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      addr_q <= 15'h0000;
      shin_q <= 16'h0000;
      shout_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      dir_q <= scsc_pkg::RST_DIR;
      user_q <= scsc_pkg::RST_USER;
      cc0_q <= scsc_pkg::RST_CC0;
      cc1_q <= scsc_pkg::RST_CC1;
      fsa_q <= scsc_pkg::RST_FS;
      fsb_q <= scsc_pkg::RST_FS;
      ref_q <= scsc_pkg::RST_REF;
      ts_q <= scsc_pkg::RST_TS;
    end else begin
      st_q <= st_d;
      sclk_q <= sclk_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      addr_q <= addr_d;
      shin_q <= shin_d;
      shout_q <= shout_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      dir_q <= dir_d;
      user_q <= user_d;
      cc0_q <= cc0_d;
      cc1_q <= cc1_d;
      fsa_q <= fsa_d;
      fsb_q <= fsb_d;
      ref_q <= ref_d;
      ts_q <= ts_d;
    end
  end

  // ==========================================================
  // Sync reference path
  assign sr_pol = SYNC_REF_IN ^ cc1_q.invert;

  // Rising edge of the gated reference becomes an event
  always_comb begin
    sr_d = sr_pol & cc0_q.recv_en;
    srprev_d = sr_q;
    evt_d = sr_q & ~srprev_q & cc0_q.recv_en & cc0_q.proc_en;
    auto_d = (cc0_d.sel == scsc_pkg::SEL_AUTO);
  end

  // Sync reference flip-flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sr_q <= 1'b0;
      srprev_q <= 1'b0;
      evt_q <= 1'b0;
      auto_q <= 1'b1;
    end else begin
      sr_q <= sr_d;
      srprev_q <= srprev_d;
      evt_q <= evt_d;
      auto_q <= auto_d;
    end
  end

  // ==========================================================
  // Outputs
  assign SDO = sdo_q;
  assign SDO_OE = oe_q;
  assign SYNC_REF_RECEIVER_ENABLE = cc0_q.recv_en;
  assign SYNC_REF_PROCESSOR_ENABLE = cc0_q.proc_en;
  assign CAPTURE_POSITION_MAGNIFY = cc0_q.zoom;
  assign SYNC_REF_DELAY_SELECT = cc0_q.sel;
  assign AUTO_CAL_EN = auto_q;
  assign SYNC_REF_EVENT = evt_q;
  assign SAMPLE_CLOCK_PECL_MODE = cc1_q.clk_pecl;
  assign SYNC_REF_PECL_MODE = cc1_q.ref_pecl;
  assign FS_ADJUST_A = fsa_q;
  assign FS_ADJUST_B = fsb_q;
  assign REF_BYPASS = ref_q[0];
  assign TIMESTAMP_CTRL = ts_q[1:0];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  AST_HOLD: assert property (step && hold |=>
    addr_q == $past(addr_q))
    else $error("Address moved while hold set");

  AST_ASCEND: assert property (step && !hold && dir_q |=>
    addr_q == 15'($past(addr_q) + 15'h0001))
    else $error("Ascending stream did not increment");

  AST_DESCEND: assert property (step && !hold && !dir_q |=>
    addr_q == 15'($past(addr_q) - 15'h0001))
    else $error("Descending stream did not decrement");

  AST_PROC_GATE: assert property (SYNC_REF_EVENT |->
    $past(SYNC_REF_PROCESSOR_ENABLE))
    else $error("Event without processor enable");

  AST_RECV_GATE: assert property (SYNC_REF_EVENT |->
    $past(SYNC_REF_RECEIVER_ENABLE, 2))
    else $error("Event without receiver enable");

  AST_INVERT: assert property (SYNC_REF_EVENT |->
    $past(sr_pol, 2) && !$past(sr_q, 2))
    else $error("Event not on polarity-corrected edge");

  AST_ZOOM_WRITE: assert property (step && !rw_q &&
    addr_q == scsc_pkg::OFS_CLOCK_CONTROL_PRIMARY |=>
    CAPTURE_POSITION_MAGNIFY == $past(shin_q[3]))
    else $error("Magnify bit not taken from write");

  AST_AUTO_CAL: assert property (AUTO_CAL_EN ==
    (SYNC_REF_DELAY_SELECT == scsc_pkg::SEL_AUTO))
    else $error("Automatic calibration flag mismatch");

  AST_PECL_WRITE: assert property (step && !rw_q &&
    addr_q == scsc_pkg::OFS_CLOCK_CONTROL_SECONDARY |=>
    SAMPLE_CLOCK_PECL_MODE == $past(shin_q[1]) &&
    SYNC_REF_PECL_MODE == $past(shin_q[0]))
    else $error("Input mode bits not taken from write");

endmodule

// File: verif/scsc_spi_host.sv
/*
  Behavioural 4-wire serial host that configures the bank.
  Assumes it shares CLK with the bank; the bench calls xfer.
*/
`timescale 1ns/1ps
module scsc_spi_host (
  input wire logic CLK,
  output logic SCLK,
  output logic SCS_N,
  output logic SDI,
  input wire logic SDO
);
  // ==========================================================
  // Idle levels: clock parked low, select high
  initial begin
    SCLK = 1'b0;
    SCS_N = 1'b1;
    SDI = 1'b0;
  end

  // One bit: data set with clock low, read before the rise
  task automatic bit_cyc(input logic b, output logic r);
    SCLK = 1'b0;
    SDI = b;
    repeat (3) @(negedge CLK);
    r = SDO;
    SCLK = 1'b1;
    repeat (3) @(negedge CLK);
  endtask

  // Whole frame: instruction, then n bytes, first byte lowest
  task automatic xfer(input logic rd, input logic [14:0] a,
      input int n, input logic [31:0] wd, output logic [31:0] rv);
    logic [15:0] ins;
    logic r;
    ins = {rd, a};
    rv = '0;
    @(negedge CLK);
    SCS_N = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(ins[i], r);
    end
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_cyc(wd[8*k+i], r);
        rv[8*k+i] = r;
      end
    end
    SCLK = 1'b0;
    repeat (3) @(negedge CLK);
    SCS_N = 1'b1;
    SDI = ~SDI; // Released line shows no stale value
    repeat (2) @(negedge CLK);
  endtask
endmodule

// File: verif/tb_top.sv
/*
  Self-checking bench for the configuration bank.
  Assumes scsc_regs and the serial host model compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic SCLK, SCS_N, SDI, SDO, SDO_OE, ev;
  logic ref_in = 1'b0;
  logic [23:0] pos_in = 24'hC35A96;
  logic rcv, prc, mag, acal, cpecl, rpecl, byp;
  logic [3:0] dsel;
  logic [15:0] fsa, fsb;
  logic [1:0] ts;
  logic [31:0] rv;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int oe_cyc = 0;

  // ==========================================================
  // Clock, design and host
  always #12.5 CLK = ~CLK;

  scsc_regs DUT (.CLK(CLK), .SRST(SRST), .SCLK(SCLK),
    .SCS_N(SCS_N), .SDI(SDI), .SDO(SDO), .SDO_OE(SDO_OE),
    .SYNC_REF_IN(ref_in), .SYNC_CAPTURE_POSITION(pos_in),
    .SYNC_REF_RECEIVER_ENABLE(rcv),
    .SYNC_REF_PROCESSOR_ENABLE(prc),
    .CAPTURE_POSITION_MAGNIFY(mag), .SYNC_REF_DELAY_SELECT(dsel),
    .AUTO_CAL_EN(acal), .SYNC_REF_EVENT(ev),
    .SAMPLE_CLOCK_PECL_MODE(cpecl), .SYNC_REF_PECL_MODE(rpecl),
    .FS_ADJUST_A(fsa), .FS_ADJUST_B(fsb), .REF_BYPASS(byp),
    .TIMESTAMP_CTRL(ts));

  scsc_spi_host host (.CLK(CLK), .SCLK(SCLK), .SCS_N(SCS_N),
    .SDI(SDI), .SDO(SDO));

  // ==========================================================
  // Compare, access and report tasks
  task automatic chk_rd(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t read %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [23:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t pin %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [14:0] a, input int n,
      input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b0, a, n, d, x);
  endtask

  task automatic rd(input logic [14:0] a, input int n);
    host.xfer(1'b1, a, n, 32'h0, rv);
  endtask

  // Move the raw reference, count event pulses after it
  task automatic ref_edge(input logic lvl, input int exp);
    int c;
    c = 0;
    @(negedge CLK);
    ref_in = lvl;
    repeat (8) begin
      @(negedge CLK);
      if (ev === 1'b1) begin
        c++;
      end
    end
    chk_pin(24'(c), 24'(exp));
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Falling edges seen with the read driver enabled
  always @(negedge CLK) begin
    if (SDO_OE === 1'b1) begin
      oe_cyc++;
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (10) @(negedge CLK);
    SRST = 1'b0;
    chk_pin({7'h00, acal, fsa}, 24'h01A000);
    chk_pin({7'h00, SDO_OE, fsb}, 24'h00A000);
    chk_pin(24'({SDO, ev, prc, rcv, mag, cpecl, rpecl, ts}), 24'h0);
    chk_pin(24'({acal, dsel, byp}), 24'h20);
    rd(15'h010, 1);
    chk_rd(rv, 32'h0);
    chk_pin(24'(oe_cyc), 24'h000036);
    rd(15'h029, 3);
    chk_rd(rv, 32'h2000);
    rd(15'h030, 4);
    chk_rd(rv, 32'hA000A000);
    rd(15'h038, 1);
    chk_rd(rv, 32'h0);
    end_test("reset");
    wr(15'h029, 1, 32'h20);
    chk_pin(24'({prc, rcv}), 24'h1);
    chk_pin(24'(oe_cyc), 24'h0001C8);
    wr(15'h029, 1, 32'h7F);
    chk_pin(24'({prc, rcv, mag, dsel, acal}), 24'hFE);
    wr(15'h029, 1, 32'h60);
    chk_pin(24'({prc, rcv, mag, dsel, acal}), 24'hC1);
    wr(15'h02A, 1, 32'h27);
    chk_pin(24'({cpecl, rpecl}), 24'h3);
    rd(15'h02A, 1);
    chk_rd(rv, 32'h27);
    end_test("control");
    ref_edge(1'b1, 0);
    ref_edge(1'b0, 1);
    wr(15'h02A, 1, 32'h26);
    ref_edge(1'b1, 1);
    ref_edge(1'b0, 0);
    wr(15'h029, 1, 32'h20);
    ref_edge(1'b1, 0);
    end_test("events");
    wr(15'h030, 4, 32'h12345678);
    chk_pin(24'(fsa), 24'h5678);
    chk_pin(24'(fsb), 24'h1234);
    rd(15'h02C, 3);
    chk_rd(rv, 32'hC35A96);
    wr(15'h029, 1, {24'h000000, 4'h2, rv[3:0]});
    chk_pin(24'({dsel, acal}), 24'hC);
    end_test("ascend");
    wr(15'h010, 1, 32'h01);
    rd(15'h02A, 3);
    chk_rd(rv, 32'h262626);
    wr(15'h038, 2, 32'h0301);
    chk_pin(24'(byp), 24'h1);
    rd(15'h038, 1);
    chk_rd(rv, 32'h03);
    wr(15'h010, 1, 32'h00);
    wr(15'h03B, 1, 32'h02);
    chk_pin(24'(ts), 24'h2);
    end_test("hold");
    wr(15'h000, 1, 32'h00);
    wr(15'h033, 2, 32'h9ABC);
    chk_pin(24'(fsb), 24'hBC9A);
    rd(15'h033, 2);
    chk_rd(rv, 32'h9ABC);
    end_test("descend");
    tally_and_finish();
  end
endmodule
